// ===== hdl/deadband_pkg.sv
// Constants for the waveform shutdown and dead-band block
package deadband_pkg;
    localparam int          DATA_W          = 32;
    localparam int          ADDR_W          = 8;
    localparam int          DB_BITS         = 6;
    localparam int          SRC_COUNT       = 5;
    localparam int          IRQ_BITS        = 3;
    // Register byte addresses
    localparam logic [7:0]  ADDR_SRC_EN     = 8'h00;
    localparam logic [7:0]  ADDR_RISE_DB    = 8'h04;
    localparam logic [7:0]  ADDR_FALL_DB    = 8'h08;
    localparam logic [7:0]  ADDR_CONTROL    = 8'h0c;
    localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h10;
    localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h14;
    // Source enable bit positions
    localparam int          PIN_TRIP_BIT    = 0;
    localparam int          CMP1_TRIP_BIT   = 1;
    localparam int          CMP2_TRIP_BIT   = 2;
    localparam int          LOGIC2_TRIP_BIT = 3;
    localparam int          LOGIC4_TRIP_BIT = 4;
    // Control register bit positions
    localparam int          CLK_SRC_BIT     = 0;
    localparam int          SHUTDOWN_BIT    = 1;
    // Interrupt status bit positions
    localparam int          IRQ_SHUT_BIT    = 0;
    localparam int          IRQ_RISE_BIT    = 1;
    localparam int          IRQ_FALL_BIT    = 2;
    // Reset values
    localparam logic [4:0]  SRC_EN_RESET    = 5'h00;
    localparam logic [5:0]  DB_RESET        = 6'h00;
    localparam logic [2:0]  IRQ_RESET       = 3'h0;
    // Bus responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// ===== hdl/waveform_shutdown_deadband.sv
// Auto-shutdown source selection and dead-band delay for one waveform channel
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module waveform_shutdown_deadband
    import deadband_pkg::*;
#(
    parameter int DB_WIDTH = DB_BITS
) (
    input  wire logic                ref_clk,
    input  wire logic                arst_n,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [DATA_W-1:0]   s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic                data_in,
    input  wire logic                fast_internal_oscillator,
    input  wire logic                pin_routed_trip_input,
    input  wire logic                comparator_one_output,
    input  wire logic                comparator_two_output,
    input  wire logic                logic_cell_two_output,
    input  wire logic                logic_cell_four_output,
    output logic                     wave_primary,
    output logic                     wave_complement,
    output logic                     shutdown_active,
    output logic                     irq
);

    if (DB_WIDTH < 1 || DB_WIDTH > 8) begin : g_check
        $error("DB_WIDTH must lie between 1 and 8");
    end

    logic [SRC_COUNT-1:0] src_raw;
    logic [SRC_COUNT-1:0] src_meta;
    logic [SRC_COUNT-1:0] src_sync;
    logic [SRC_COUNT-1:0] src_en;
    logic [DB_WIDTH-1:0]  rise_delay_count;
    logic [DB_WIDTH-1:0]  fall_delay_count;
    logic [DB_WIDTH-1:0]  rise_cnt;
    logic [DB_WIDTH-1:0]  fall_cnt;
    logic                 clk_source;
    logic [IRQ_BITS-1:0]  irq_status;
    logic [IRQ_BITS-1:0]  irq_mask;
    logic                 data_meta;
    logic                 data_sync;
    logic                 data_prev;
    logic                 osc_meta;
    logic                 osc_sync;
    logic                 osc_prev;
    logic                 resume_wait;
    logic                 aw_have;
    logic                 w_have;
    logic [ADDR_W-1:0]    aw_addr;
    logic [DATA_W-1:0]    w_data;
    logic                 w_lane0;
    logic                 wr_go;
    logic                 wr_hit;
    logic                 rd_hit;
    logic [DATA_W-1:0]    rd_value;
    logic                 trip;
    logic                 gen_tick;
    logic                 rise_edge;
    logic                 fall_edge;
    logic                 release_req;
    logic                 outputs_off;

    // Decodes an address to a mapped register
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a == ADDR_SRC_EN) || (a == ADDR_RISE_DB) || (a == ADDR_FALL_DB) ||
                 (a == ADDR_CONTROL) || (a == ADDR_IRQ_STAT) || (a == ADDR_IRQ_MASK);
    endfunction

    assign src_raw = {logic_cell_four_output, logic_cell_two_output, comparator_two_output,
                      comparator_one_output, pin_routed_trip_input};

    // Two-stage synchronisers on every trip source
    for (genvar i = 0; i < SRC_COUNT; i++) begin : g_sync
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                src_meta[i] <= 1'b0;
                src_sync[i] <= 1'b0;
            end else begin
                src_meta[i] <= src_raw[i];
                src_sync[i] <= src_meta[i];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_meta <= 1'b0;
            data_sync <= 1'b0;
            data_prev <= 1'b0;
            osc_meta  <= 1'b0;
            osc_sync  <= 1'b0;
            osc_prev  <= 1'b0;
        end else begin
            data_meta <= data_in;
            data_sync <= data_meta;
            // An edge waits for a generator tick, so each delay spans n to n+1 periods
            if (gen_tick) begin
                data_prev <= data_sync;
            end
            osc_meta  <= fast_internal_oscillator;
            osc_sync  <= osc_meta;
            osc_prev  <= osc_sync;
        end
    end

    assign rise_edge = data_sync && !data_prev;
    assign fall_edge = !data_sync && data_prev;
    assign gen_tick  = clk_source ? (osc_sync && !osc_prev) : 1'b1;
    assign trip      = |(src_sync & src_en);

    // Register write path
    assign wr_go       = aw_have && w_have && !s_axi_bvalid;
    assign wr_hit      = mapped(aw_addr);
    assign release_req = wr_go && w_lane0 && (aw_addr == ADDR_CONTROL) && w_data[SHUTDOWN_BIT];

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_have       <= 1'b0;
            w_have        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= '0;
            w_lane0       <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!aw_have && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_lane0      <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end else if (!w_have && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (wr_go) begin
                aw_have      <= 1'b0;
                w_have       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            src_en           <= SRC_EN_RESET;
            rise_delay_count <= DB_WIDTH'(DB_RESET);
            fall_delay_count <= DB_WIDTH'(DB_RESET);
            clk_source       <= 1'b0;
            irq_mask         <= IRQ_RESET;
        end else if (wr_go && w_lane0) begin
            if (aw_addr == ADDR_SRC_EN) begin
                src_en <= w_data[SRC_COUNT-1:0];
            end else if (aw_addr == ADDR_RISE_DB) begin
                rise_delay_count <= w_data[DB_WIDTH-1:0];
            end else if (aw_addr == ADDR_FALL_DB) begin
                fall_delay_count <= w_data[DB_WIDTH-1:0];
            end else if (aw_addr == ADDR_CONTROL) begin
                clk_source <= w_data[CLK_SRC_BIT];
            end else if (aw_addr == ADDR_IRQ_MASK) begin
                irq_mask <= w_data[IRQ_BITS-1:0];
            end
        end
    end

    // Read path
    always_comb begin
        rd_value = '0;
        rd_hit   = mapped(s_axi_araddr);
        if (s_axi_araddr == ADDR_SRC_EN) begin
            rd_value[SRC_COUNT-1:0] = src_en;
        end else if (s_axi_araddr == ADDR_RISE_DB) begin
            rd_value[DB_WIDTH-1:0] = rise_delay_count;
        end else if (s_axi_araddr == ADDR_FALL_DB) begin
            rd_value[DB_WIDTH-1:0] = fall_delay_count;
        end else if (s_axi_araddr == ADDR_CONTROL) begin
            rd_value[CLK_SRC_BIT]  = clk_source;
            rd_value[SHUTDOWN_BIT] = shutdown_active;
        end else if (s_axi_araddr == ADDR_IRQ_STAT) begin
            rd_value[IRQ_BITS-1:0] = irq_status;
        end else if (s_axi_araddr == ADDR_IRQ_MASK) begin
            rd_value[IRQ_BITS-1:0] = irq_mask;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_value;
            s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // Shutdown flag: a trip in the release cycle keeps it set
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            shutdown_active <= 1'b0;
            resume_wait     <= 1'b0;
        end else begin
            if (trip) begin
                shutdown_active <= 1'b1;
            end else if (release_req) begin
                shutdown_active <= 1'b0;
            end
            if (trip) begin
                resume_wait <= 1'b1;
            end else if (!shutdown_active && rise_edge) begin
                resume_wait <= 1'b0;
            end
        end
    end

    // Outputs resume only at the next data rise after release
    assign outputs_off = trip || shutdown_active || (resume_wait && !rise_edge);

    // Dead-band counters and channel outputs
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rise_cnt     <= '0;
            wave_primary <= 1'b0;
        end else if (outputs_off || !data_sync) begin
            rise_cnt     <= '0;
            wave_primary <= 1'b0;
        end else if (rise_edge || (resume_wait && data_sync)) begin
            rise_cnt     <= rise_delay_count;
            wave_primary <= (rise_delay_count == '0);
        end else if (rise_cnt != '0 && gen_tick) begin
            rise_cnt <= rise_cnt - 1'b1;
            if (rise_cnt == DB_WIDTH'(1)) begin
                wave_primary <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fall_cnt        <= '0;
            wave_complement <= 1'b0;
        end else if (outputs_off || data_sync) begin
            fall_cnt        <= '0;
            wave_complement <= 1'b0;
        end else if (fall_edge) begin
            fall_cnt        <= fall_delay_count;
            wave_complement <= (fall_delay_count == '0);
        end else if (fall_cnt != '0 && gen_tick) begin
            fall_cnt <= fall_cnt - 1'b1;
            if (fall_cnt == DB_WIDTH'(1)) begin
                wave_complement <= 1'b1;
            end
        end
    end

    // Sticky interrupt status, write one to clear, set wins
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_status <= IRQ_RESET;
            irq <= 1'b0;
        end else begin
            for (int b = 0; b < IRQ_BITS; b++) begin
                if ((b == IRQ_SHUT_BIT && trip && !shutdown_active) ||
                    (b == IRQ_RISE_BIT && rise_edge) || (b == IRQ_FALL_BIT && fall_edge)) begin
                    irq_status[b] <= 1'b1;
                end else if (wr_go && w_lane0 && aw_addr == ADDR_IRQ_STAT && w_data[b]) begin
                    irq_status[b] <= 1'b0;
                end
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    AST_LOGIC4_TRIP: assert property (@(posedge ref_clk) disable iff (!arst_n)
        src_sync[LOGIC4_TRIP_BIT] && src_en[LOGIC4_TRIP_BIT] |=> shutdown_active && !wave_primary)
        else $error("logic cell four trip did not shut down");
    AST_LOGIC2_TRIP: assert property (@(posedge ref_clk) disable iff (!arst_n)
        src_sync[LOGIC2_TRIP_BIT] && src_en[LOGIC2_TRIP_BIT] |=> shutdown_active && !wave_complement)
        else $error("logic cell two trip did not shut down");
    AST_CMP2_TRIP: assert property (@(posedge ref_clk) disable iff (!arst_n)
        src_sync[CMP2_TRIP_BIT] && src_en[CMP2_TRIP_BIT] |=> shutdown_active)
        else $error("comparator two trip did not shut down");
    AST_CMP1_TRIP: assert property (@(posedge ref_clk) disable iff (!arst_n)
        src_sync[CMP1_TRIP_BIT] && src_en[CMP1_TRIP_BIT] |=> shutdown_active)
        else $error("comparator one trip did not shut down");
    AST_PIN_TRIP: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !shutdown_active && src_sync[PIN_TRIP_BIT] && src_en[PIN_TRIP_BIT] |=> shutdown_active)
        else $error("pin trip did not shut down");
    AST_RISE_DELAY: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !clk_source && rise_edge && !outputs_off && rise_delay_count == DB_WIDTH'(2) ##1 data_sync [*2]
        |-> !wave_primary ##1 wave_primary)
        else $error("rising dead-band of two cycles not honoured");
    AST_FALL_DELAY: assert property (@(posedge ref_clk) disable iff (!arst_n)
        fall_edge && !outputs_off && |fall_delay_count |=> !wave_complement && fall_cnt == $past(fall_delay_count))
        else $error("falling dead-band not loaded");
    AST_ZERO_BYPASS: assert property (@(posedge ref_clk) disable iff (!arst_n)
        rise_edge && !outputs_off && rise_delay_count == '0 |=> wave_primary)
        else $error("zero count did not bypass dead-band");
    AST_UPPER_ZERO: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_axi_rvalid |-> s_axi_rdata[DATA_W-1:DB_WIDTH] == '0)
        else $error("unimplemented bits read non-zero");
    AST_REG_WRITE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wr_go && w_lane0 && aw_addr == ADDR_RISE_DB |=> rise_delay_count == $past(w_data[DB_WIDTH-1:0]))
        else $error("rising count write lost");
    AST_SHUTDOWN_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        shutdown_active && !release_req |=> shutdown_active ##0 !wave_primary && !wave_complement)
        else $error("shutdown released without request");
    AST_OSC_STALL: assert property (@(posedge ref_clk) disable iff (!arst_n)
        clk_source && !(osc_sync && !osc_prev) && rise_cnt > DB_WIDTH'(1) && !outputs_off && !rise_edge && data_sync
        |=> rise_cnt == $past(rise_cnt))
        else $error("counter moved without oscillator tick");
    AST_SYNC_EDGE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        rise_edge |-> $past(data_meta) && (!$past(data_sync) || $past(rise_edge)))
        else $error("edge seen without synchroniser");

endmodule
`default_nettype wire

// ===== bench/gate_driver_model.sv
// Gate driver pair that watches the complementary outputs for shoot-through
`timescale 1ns/100ps
`default_nettype none
module gate_driver_model (
    input  wire logic ref_clk,
    input  wire logic arst_n,
    input  wire logic wave_primary,
    input  wire logic wave_complement,
    output logic      overlap_seen
);
    // Both switches on at once would short the supply rail
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            overlap_seen <= 1'b0;
        end else if (wave_primary && wave_complement) begin
            overlap_seen <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== bench/waveform_shutdown_deadband_test.sv
// Self-checking testbench for the shutdown and dead-band block
`timescale 1ns/100ps
`default_nettype none
module waveform_shutdown_deadband_test
    import deadband_pkg::*;
;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic              ref_clk, arst_n, data_in, fast_internal_oscillator, overlap_seen;
    logic              wave_primary, wave_complement, shutdown_active, irq;
    logic [4:0]        trip_src;
    int                miscompares, checks;

    waveform_shutdown_deadband dut (
        .ref_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .data_in, .fast_internal_oscillator, .pin_routed_trip_input(trip_src[PIN_TRIP_BIT]),
        .comparator_one_output(trip_src[CMP1_TRIP_BIT]), .comparator_two_output(trip_src[CMP2_TRIP_BIT]),
        .logic_cell_two_output(trip_src[LOGIC2_TRIP_BIT]), .logic_cell_four_output(trip_src[LOGIC4_TRIP_BIT]),
        .wave_primary, .wave_complement, .shutdown_active, .irq
    );
    gate_driver_model gate_drivers (.ref_clk, .arst_n, .wave_primary, .wave_complement, .overlap_seen);

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Free-running oscillator, offset so its edges never meet the bus clock
    initial begin
        fast_internal_oscillator = 1'b0;
        #1;
        forever #10 fast_internal_oscillator = ~fast_internal_oscillator;
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h got %h", name, exp, got);
        end
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge ref_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge ref_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Moves data_in and counts cycles until the matching output turns on
    task automatic measure(input logic v, input int lo, input int hi);
        int n;
        n = 0;
        @(posedge ref_clk);
        data_in <= v;
        do begin
            @(posedge ref_clk);
            n++;
        end while ((v ? wave_primary : wave_complement) !== 1'b1 && n < 400);
        checks++;
        if (n < lo || n > hi) begin
            miscompares++;
            $display("[FAIL] delay expected %0d..%0d got %0d", lo, hi, n);
        end
    endtask

    task automatic test_registers();
        logic [1:0]  r;
        logic [31:0] d;
        logic [7:0]  a [3] = '{ADDR_SRC_EN, ADDR_RISE_DB, ADDR_FALL_DB};
        logic [31:0] m [3] = '{32'h0000001f, 32'h0000003f, 32'h0000003f};
        for (int i = 0; i < 3; i++) begin
            axi_read(a[i], d, r);
            check("reset_value", 32'h0, d);
            axi_write(a[i], 32'hffffffff, r);
            check("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
            axi_read(a[i], d, r);
            check("readback", m[i], d);
            axi_write(a[i], 32'h0, r);
            axi_read(a[i], d, r);
            check("cleared", 32'h0, d);
        end
        axi_write(8'h20, 32'h1, r);
        check("unmapped_bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        axi_read(8'h20, d, r);
        check("unmapped_rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        check("unmapped_rdata", 32'h0, d);
        // Lane zero strobe low: answered OKAY, nothing written
        s_axi_wstrb <= 4'he;
        axi_write(ADDR_RISE_DB, 32'h3f, r);
        s_axi_wstrb <= 4'hf;
        check("lane0_bresp", {30'h0, RESP_OKAY}, {30'h0, r});
        axi_read(ADDR_RISE_DB, d, r);
        check("lane0_ignored", 32'h0, d);
    endtask

    task automatic test_deadband();
        logic [1:0] r;
        logic [31:0] d;
        logic [5:0] rise_n [4] = '{6'h00, 6'h01, 6'h02, 6'h3f};
        logic [5:0] fall_n [4] = '{6'h03, 6'h00, 6'h3f, 6'h01};
        for (int i = 0; i < 4; i++) begin
            axi_write(ADDR_RISE_DB, {26'h0, rise_n[i]}, r);
            axi_write(ADDR_FALL_DB, {26'h0, fall_n[i]}, r);
            measure(1'b1, rise_n[i] + 1, rise_n[i] + 5);
            measure(1'b0, fall_n[i] + 1, fall_n[i] + 5);
        end
        axi_write(ADDR_CONTROL, 32'h1, r);
        axi_read(ADDR_CONTROL, d, r);
        check("clock_source", 32'h1, d & 32'h1);
        axi_write(ADDR_RISE_DB, 32'h4, r);
        measure(1'b1, 15, 40);
        measure(1'b0, 1, 80);
        axi_write(ADDR_CONTROL, 32'h0, r);
    endtask

    task automatic test_shutdown();
        logic [1:0]  r;
        logic [31:0] d;
        axi_write(ADDR_IRQ_MASK, 32'h1, r);
        axi_write(ADDR_IRQ_STAT, 32'h7, r);
        measure(1'b1, 1, 70);
        axi_read(ADDR_IRQ_STAT, d, r);
        check("rise_event", 32'h2, d & 32'h6);
        for (int i = 0; i < SRC_COUNT; i++) begin
            axi_write(ADDR_SRC_EN, 32'h1f & ~(32'h1 << i), r);
            trip_src[i] <= 1'b1;
            repeat (8) @(posedge ref_clk);
            check("trip_disabled", 32'h0, {31'h0, shutdown_active});
            axi_write(ADDR_SRC_EN, 32'h1 << i, r);
            repeat (4) @(posedge ref_clk);
            check("trip_enabled", 32'h1, {31'h0, shutdown_active});
            check("outputs_off", 32'h0, {30'h0, wave_primary, wave_complement});
            check("irq_raised", 32'h1, {31'h0, irq});
            axi_read(ADDR_CONTROL, d, r);
            check("flag_set", 32'h2, d & 32'h2);
            trip_src[i] <= 1'b0;
            data_in     <= 1'b0;
            repeat (4) @(posedge ref_clk);
            axi_write(ADDR_CONTROL, 32'h2, r);
            axi_write(ADDR_IRQ_STAT, 32'h1, r);
            repeat (2) @(posedge ref_clk);
            check("flag_clear", 32'h0, {31'h0, shutdown_active});
            check("irq_cleared", 32'h0, {31'h0, irq});
            measure(1'b1, 1, 70);
        end
        axi_write(ADDR_IRQ_MASK, 32'h0, r);
        axi_write(ADDR_SRC_EN, 32'h1, r);
        trip_src[0] <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check("irq_masked", 32'h0, {31'h0, irq});
        axi_read(ADDR_IRQ_STAT, d, r);
        check("status_sticky", 32'h1, d & 32'h1);
        trip_src[0] <= 1'b0;
        repeat (4) @(posedge ref_clk);
        axi_write(ADDR_CONTROL, 32'h2, r);
        axi_write(ADDR_IRQ_STAT, 32'h1, r);
        axi_read(ADDR_IRQ_STAT, d, r);
        check("status_w1c", 32'h0, d & 32'h1);
    endtask

    task automatic tally_and_finish();
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        miscompares++;
        tally_and_finish();
    end

    initial begin
        arst_n        = 1'b0;
        data_in       = 1'b0;
        trip_src      = 5'h00;
        s_axi_awaddr  = 8'h00;
        s_axi_araddr  = 8'h00;
        s_axi_wdata   = 32'h0;
        s_axi_wstrb   = 4'hf;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
        miscompares   = 0;
        checks        = 0;
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        test_registers();
        test_deadband();
        test_shutdown();
        check("no_overlap", 32'h0, {31'h0, overlap_seen});
        tally_and_finish();
    end
endmodule
`default_nettype wire
